// ### verilog/ostl_pkg.sv
package ostl_pkg;
    localparam int CHANNELS = 8;
    localparam int PAYLOAD_BITS = 10;
    localparam int FRAME_BITS = 12;
    localparam int WORD_W = CHANNELS * PAYLOAD_BITS;
    localparam int FIFO_DEPTH = 8;
    localparam int PRBS_W = 7;
    localparam int SEL_W = 4;

    localparam logic START_BIT = 1'b1;
    localparam logic STOP_BIT = 1'b0;
    // six ones then six zeros, first bit in bit 0
    localparam logic [11:0] SYNC_FRAME = 12'h03F;
    localparam logic [3:0] LAST_BIT = 4'hB;
    localparam logic [2:0] SYNC_FRAMES = 3'h4;
    localparam logic [3:0] SEL_ALL = 4'h8;
    localparam logic [6:0] PRBS_SEED = 7'h7F;
    localparam int PRBS_TAP_HI = 6;
    localparam int PRBS_TAP_LO = 5;

    localparam int CLK_PERIOD_NS = 20;
    localparam int PLL_LOCK_NS = 1000;
    localparam int PLL_LOCK_CYCLES =
        (PLL_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic [3:0] OFF_CTRL = 4'h0;
    localparam logic [3:0] OFF_SLEEP = 4'h4;
    localparam logic [3:0] OFF_SYNC = 4'h8;
    localparam logic [3:0] OFF_STATUS = 4'hC;

    localparam int CTRL_DEN_BIT = 0;
    localparam int CTRL_MS_BIT = 1;
    localparam int CTRL_ACT_BIT = 2;
    localparam int CTRL_SEL_LSB = 4;
    localparam int STAT_SYNC_LSB = 8;
    localparam int STAT_RUN_BIT = 16;

    localparam logic [3:0] SEL_RESET = 4'hF;
    localparam logic [7:0] SLEEP_RESET = 8'hFF;

    typedef enum logic [1:0] {ST_SLEEP, ST_LOCK, ST_RUN} ostl_pll_t;
endpackage

// ### verilog/ostl_stream_if.sv
`timescale 1ns/1ps
interface ostl_stream_if #(parameter int W = 80);
    logic [W-1:0] data;
    logic valid;
    logic ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface // ostl_stream_if

// ### verilog/ostl_fifo.sv
`timescale 1ns/1ps
module ostl_fifo #(
    parameter int W = 80,
    parameter int DEPTH = 8
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    ostl_stream_if.snk in_s,
    ostl_stream_if.src out_s
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic [AW:0] cnt_d;
    logic in_rdy_q;
    logic out_vld_q;

    function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
        next_ptr = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
    endfunction

    wire push = in_s.valid && in_rdy_q;
    wire pop = out_vld_q && out_s.ready;

    assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    assign in_s.ready = in_rdy_q;
    assign out_s.valid = out_vld_q;
    assign out_s.data = mem_q[rd_q];

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_q[wr_q] <= in_s.data;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            in_rdy_q <= 1'b0;
            out_vld_q <= 1'b0;
        end else begin
            if (push) wr_q <= next_ptr(wr_q);
            if (pop) rd_q <= next_ptr(rd_q);
            cnt_q <= cnt_d;
            in_rdy_q <= cnt_d < (AW+1)'(DEPTH);
            out_vld_q <= cnt_d != '0;
        end
    end
endmodule // ostl_fifo

// ### verilog/ostl_top.sv
`timescale 1ns/1ps
module ostl_top #(
    parameter int CHANNELS = ostl_pkg::CHANNELS,
    parameter int FIFO_DEPTH = ostl_pkg::FIFO_DEPTH,
    parameter int LOCK_CYCLES = ostl_pkg::PLL_LOCK_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic word_in_valid,
    input wire logic [CHANNELS*ostl_pkg::PAYLOAD_BITS-1:0]
        channel_parallel_word_in,
    output logic word_in_ready,
    output logic [CHANNELS-1:0] channel_serial_out,
    output logic [CHANNELS-1:0] channel_serial_oe
);
    localparam int PW = ostl_pkg::PAYLOAD_BITS;
    localparam int FW = ostl_pkg::FRAME_BITS;
    localparam int RW = ostl_pkg::PRBS_W;
    localparam int WW = CHANNELS * PW;
    localparam int LW = $clog2(LOCK_CYCLES + 1);

    // ---------------- register bus ----------------
    logic wait_q;
    logic [31:0] rdata_q;
    logic den_q;
    logic ms_q;
    logic act_q;
    logic [ostl_pkg::SEL_W-1:0] sel_q;
    logic [CHANNELS-1:0] sleep_n_q;
    logic [CHANNELS-1:0] sync_req_q;
    logic [31:0] rd_mux;

    wire access = avs_read || avs_write;
    wire wr_en = avs_write && !wait_q && avs_byteenable[0];
    wire hit_ctrl = avs_address == ostl_pkg::OFF_CTRL;
    wire hit_sleep = avs_address == ostl_pkg::OFF_SLEEP;
    wire hit_sync = avs_address == ostl_pkg::OFF_SYNC;
    wire hit_stat = avs_address == ostl_pkg::OFF_STATUS;

    // the test is reachable only through this control word; there is no
    // separate test-access port
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            den_q <= 1'b0;
            ms_q <= 1'b0;
            act_q <= 1'b0;
            sel_q <= ostl_pkg::SEL_RESET;
        end else if (wr_en && hit_ctrl) begin
            den_q <= avs_writedata[ostl_pkg::CTRL_DEN_BIT];
            ms_q <= avs_writedata[ostl_pkg::CTRL_MS_BIT];
            act_q <= avs_writedata[ostl_pkg::CTRL_ACT_BIT];
            sel_q <= avs_writedata[ostl_pkg::CTRL_SEL_LSB +: 4];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sleep_n_q <= ostl_pkg::SLEEP_RESET;
            sync_req_q <= '0;
        end else begin
            if (wr_en && hit_sleep) sleep_n_q <= avs_writedata[7:0];
            if (wr_en && hit_sync) sync_req_q <= avs_writedata[7:0];
        end
    end

    // ---------------- pll model and frame timing ----------------
    ostl_pkg::ostl_pll_t pll_q;
    ostl_pkg::ostl_pll_t pll_d;
    logic [LW-1:0] lock_q;
    logic [3:0] bit_q;

    wire run = pll_q == ostl_pkg::ST_RUN;
    wire lock_done = lock_q == LW'(LOCK_CYCLES - 1);
    // one tick per word period; every channel starts its frame here
    wire tick = run && bit_q == ostl_pkg::LAST_BIT;

    always_comb begin
        pll_d = pll_q;
        case (pll_q)
            ostl_pkg::ST_SLEEP: begin
                if (ms_q) pll_d = ostl_pkg::ST_LOCK;
            end
            ostl_pkg::ST_LOCK: begin
                if (!ms_q) pll_d = ostl_pkg::ST_SLEEP;
                else if (lock_done) pll_d = ostl_pkg::ST_RUN;
            end
            default: begin
                if (!ms_q) pll_d = ostl_pkg::ST_SLEEP;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pll_q <= ostl_pkg::ST_SLEEP;
            lock_q <= '0;
        end else begin
            pll_q <= pll_d;
            lock_q <= (pll_q == ostl_pkg::ST_LOCK) ? lock_q + LW'(1) : '0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bit_q <= ostl_pkg::LAST_BIT;
        end else if (!run || tick) begin
            bit_q <= run ? 4'h0 : ostl_pkg::LAST_BIT;
        end else begin
            bit_q <= bit_q + 4'h1;
        end
    end

    // ---------------- word buffer ----------------
    ostl_stream_if #(.W(WW)) in_s ();
    ostl_stream_if #(.W(WW)) out_s ();
    logic [WW-1:0] hold_q;

    assign in_s.data = channel_parallel_word_in;
    assign in_s.valid = word_in_valid;
    assign word_in_ready = in_s.ready;
    // drained only on ticks, so a sleeping device back-pressures the source
    assign out_s.ready = tick;

    ostl_fifo #(.W(WW), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .in_s(in_s),
        .out_s(out_s)
    );

    // an empty buffer repeats the last word rather than idling, which would
    // look repetitive to the far receiver
    wire [WW-1:0] word_w = out_s.valid ? out_s.data : hold_q;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            hold_q <= '0;
        end else if (tick && out_s.valid) begin
            hold_q <= out_s.data;
        end
    end

    // ---------------- test select decode ----------------
    function automatic logic [CHANNELS-1:0] test_decode(
        input logic act, input logic [3:0] sel);
        test_decode = '0;
        if (!act) test_decode = '0;
        else if (sel < ostl_pkg::SEL_ALL)
            test_decode = CHANNELS'(1) << sel;
        else if (sel == ostl_pkg::SEL_ALL) test_decode = '1;
        else test_decode = '0;
    endfunction

    wire [CHANNELS-1:0] test_sel_w = test_decode(act_q, sel_q);

    // ten steps of x^7 + x^6 + 1; returns {next state, payload}
    function automatic logic [RW+PW-1:0] prbs_step(input logic [RW-1:0] s);
        logic [RW-1:0] r;
        logic [PW-1:0] w;
        logic fb;
        r = s;
        w = '0;
        for (int i = 0; i < PW; i++) begin
            fb = r[ostl_pkg::PRBS_TAP_HI] ^ r[ostl_pkg::PRBS_TAP_LO];
            w[i] = fb;
            r = {r[RW-2:0], fb};
        end
        prbs_step = {r, w};
    endfunction

    function automatic logic [FW-1:0] frame_of(input logic [PW-1:0] p);
        frame_of = {ostl_pkg::STOP_BIT, p, ostl_pkg::START_BIT};
    endfunction

    // ---------------- per-channel serializers ----------------
    logic [CHANNELS-1:0] test_on_q;
    logic [CHANNELS-1:0] sync_active_q;
    logic [CHANNELS-1:0] out_q;
    logic [CHANNELS-1:0] oe_q;
    logic [2:0] sync_cnt_q [CHANNELS];

    for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
        logic [FW-1:0] frame_q;
        logic [RW-1:0] prbs_q;
        logic [2:0] cnt_d;
        logic [FW-1:0] frame_d;
        logic [RW+PW-1:0] step_w;
        logic sync_w;
        logic test_w;

        assign step_w = prbs_step(prbs_q);
        assign cnt_d = !sync_req_q[c] ? 3'h0 :
            (sync_cnt_q[c] == ostl_pkg::SYNC_FRAMES) ? sync_cnt_q[c] :
            sync_cnt_q[c] + 3'h1;
        assign sync_w = cnt_d == ostl_pkg::SYNC_FRAMES;
        assign test_w = test_sel_w[c] && !sync_w && sleep_n_q[c];
        assign frame_d = sync_w ? ostl_pkg::SYNC_FRAME :
            test_w ? frame_of(step_w[PW-1:0]) :
            frame_of(word_w[c*PW +: PW]);

        // a waking channel starts afresh, like the whole device does
        always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
                sync_cnt_q[c] <= '0;
                prbs_q <= ostl_pkg::PRBS_SEED;
            end else if (!sleep_n_q[c] || !run) begin
                sync_cnt_q[c] <= '0;
                prbs_q <= ostl_pkg::PRBS_SEED;
            end else if (tick) begin
                sync_cnt_q[c] <= cnt_d;
                if (test_w) prbs_q <= step_w[PW +: RW];
            end
        end

        always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
                frame_q <= '0;
                test_on_q[c] <= 1'b0;
                sync_active_q[c] <= 1'b0;
            end else if (tick) begin
                frame_q <= frame_d;
                test_on_q[c] <= test_w;
                sync_active_q[c] <= sync_w;
            end
        end

        // enable only gates the driver; serializer state keeps running
        always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
                out_q[c] <= 1'b0;
                oe_q[c] <= 1'b0;
            end else begin
                out_q[c] <= !run ? 1'b0 :
                    tick ? frame_d[0] : frame_q[bit_q + 4'h1];
                oe_q[c] <= den_q && run && sleep_n_q[c];
            end
        end
    end

    assign channel_serial_out = out_q;
    assign channel_serial_oe = oe_q;

    // ---------------- bus answer ----------------
    always_comb begin
        rd_mux = '0;
        if (hit_ctrl) begin
            rd_mux[ostl_pkg::CTRL_DEN_BIT] = den_q;
            rd_mux[ostl_pkg::CTRL_MS_BIT] = ms_q;
            rd_mux[ostl_pkg::CTRL_ACT_BIT] = act_q;
            rd_mux[ostl_pkg::CTRL_SEL_LSB +: 4] = sel_q;
        end else if (hit_sleep) begin
            rd_mux[7:0] = sleep_n_q;
        end else if (hit_sync) begin
            rd_mux[7:0] = sync_req_q;
        end else if (hit_stat) begin
            rd_mux[7:0] = test_on_q;
            rd_mux[ostl_pkg::STAT_SYNC_LSB +: 8] = sync_active_q;
            rd_mux[ostl_pkg::STAT_RUN_BIT] = run;
        end
    end

    // every access waits exactly one cycle
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wait_q <= 1'b1;
            rdata_q <= '0;
        end else begin
            wait_q <= !(access && wait_q);
            if (avs_read && wait_q) rdata_q <= rd_mux;
        end
    end

    assign avs_waitrequest = wait_q;
    assign avs_readdata = rdata_q;

    // ---------------- checks ----------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    sequence s_frame;
        channel_serial_out == '1 ##11 channel_serial_out == '0;
    endsequence

    sequence s_sync0;
        (sync_active_q[0] && channel_serial_out[0]) [*6]
            ##1 !channel_serial_out[0] [*6];
    endsequence

    AST_GATE: assert property (tick && !act_q |=> test_on_q == '0)
        else $error("test ran while not activated");
    AST_ONE: assert property (tick && act_q && sel_q < ostl_pkg::SEL_ALL
        |=> test_on_q == ((CHANNELS'(1) << $past(sel_q))
            & $past(sleep_n_q) & ~sync_active_q))
        else $error("single channel test decode wrong");
    AST_ALL: assert property (tick && act_q && sel_q == ostl_pkg::SEL_ALL
        |=> test_on_q == ($past(sleep_n_q) & ~sync_active_q))
        else $error("all channel test decode wrong");
    AST_NONE: assert property (tick && sel_q > ostl_pkg::SEL_ALL
        |=> test_on_q == '0)
        else $error("reserved select started a test");
    AST_FRAME: assert property (tick |=> s_frame)
        else $error("start or stop bit wrong");
    AST_DEN: assert property (!den_q |=> channel_serial_oe == '0)
        else $error("driver on while enable low");
    // five quiet cycles hold for any lock time of four cycles or more
    AST_WAKE: assert property ($rose(ms_q)
        |-> (pll_q != ostl_pkg::ST_RUN && channel_serial_oe == '0) [*5])
        else $error("outputs on before re-initialisation");
    AST_SLEEP: assert property (!ms_q |=> pll_q == ostl_pkg::ST_SLEEP)
        else $error("pll kept running in sleep");
    AST_SYNC: assert property (tick && sync_req_q[0] && sleep_n_q[0]
        && sync_cnt_q[0] == ostl_pkg::SYNC_FRAMES - 3'h1 |=> s_sync0)
        else $error("sync pattern not sent after four words");
    AST_SYNC_EARLY: assert property (tick
        && sync_cnt_q[0] < ostl_pkg::SYNC_FRAMES - 3'h1
        |=> !sync_active_q[0])
        else $error("sync started too early");
endmodule // ostl_top

// ### verif/ostl_deser_model.sv
`timescale 1ns/1ps
module ostl_deser_model (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [7:0] line,
    input wire logic [7:0] oe,
    output logic [7:0] fr_v,
    output logic [79:0] fr_d,
    output int n_err
);
    logic [11:0] sh [8];
    logic [11:0] nsh;
    int ph [8];
    logic [7:0] lock;
    // locks only on a sync frame: random payload could fake a frame edge
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lock <= 8'h00;
            fr_v <= 8'h00;
            fr_d <= '0;
            n_err <= 0;
        end else begin
            fr_v <= 8'h00;
            for (int c = 0; c < 8; c++) begin
                nsh = {line[c], sh[c][11:1]};
                sh[c] <= nsh;
                ph[c] <= (ph[c] == 11) ? 0 : ph[c] + 1;
                if (oe[c] !== 1'b1) begin
                    lock[c] <= 1'b0;
                end else if (!lock[c]) begin
                    if (nsh == 12'h003F) begin
                        lock[c] <= 1'b1;
                        ph[c] <= 0;
                    end
                end else if (ph[c] == 11) begin
                    if (nsh[0] !== 1'b1 || nsh[11] !== 1'b0) begin
                        n_err <= n_err + 1;
                        lock[c] <= 1'b0;
                    end
                    fr_v[c] <= 1'b1;
                    fr_d[c*10+:10] <= nsh[10:1];
                end
            end
        end
    end
endmodule // ostl_deser_model

// ### verif/tb.sv
`timescale 1ns/1ps
module tb;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic word_in_valid = 1'b0;
    logic [79:0] channel_parallel_word_in = '0;
    logic word_in_ready;
    logic [7:0] channel_serial_out;
    logic [7:0] channel_serial_oe;
    logic [7:0] fr_v;
    logic [79:0] fr_d;
    int n_err;
    int n_mismatch = 0;
    int total_checks = 0;
    int seed = 32'h40ff;
    logic [9:0] rxq [8][$];
    logic [79:0] sent [$];
    logic [31:0] rd;
    logic [95:0] rw;
    logic saw_full = 1'b0;
    int sz [8];

    initial begin
        forever #10 clk_sys = ~clk_sys;
    end

    ostl_top #(.LOCK_CYCLES(4)) ostl_top_inst (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .word_in_valid(word_in_valid),
        .channel_parallel_word_in(channel_parallel_word_in),
        .word_in_ready(word_in_ready),
        .channel_serial_out(channel_serial_out),
        .channel_serial_oe(channel_serial_oe)
    );

    ostl_deser_model ostl_deser_model_inst (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .line(channel_serial_out),
        .oe(channel_serial_oe),
        .fr_v(fr_v),
        .fr_d(fr_d),
        .n_err(n_err)
    );

    always @(posedge clk_sys) begin
        for (int c = 0; c < 8; c++) begin
            if (fr_v[c]) rxq[c].push_back(fr_d[c*10+:10]);
        end
    end

    task automatic wrap_up();
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic chk_frame(input logic [9:0] g, input logic [9:0] e);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // x^7 + x^6 + 1, ten steps a frame; the last seven payload bits are
    // the whole generator state, so each frame predicts the next one
    function automatic logic [9:0] prbs_next(input logic [9:0] p);
        logic [6:0] r;
        logic [9:0] q;
        for (int i = 0; i < 7; i++) r[i] = p[9 - i];
        for (int i = 0; i < 10; i++) begin
            q[i] = r[6] ^ r[5];
            r = {r[5:0], q[i]};
        end
        return q;
    endfunction

    // request held until the rising edge at which waitrequest is low
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d, input logic [3:0] be);
        int n;
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= w;
        avs_read <= !w;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (avs_waitrequest !== 1'b0) begin
            n_mismatch++;
            wrap_up();
        end
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hF);
    endtask

    task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000, 4'hF);
        chk_reg(rd, e);
    endtask

    // caller stands at a rising edge; returns at the edge that took the word
    task automatic push(input logic [79:0] w);
        channel_parallel_word_in <= w;
        word_in_valid <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (word_in_ready !== 1'b1) saw_full = 1'b1;
        end while (word_in_ready !== 1'b1);
        sent.push_back(w);
    endtask

    task automatic chk_stream();
        int k;
        int n;
        n = sent.size();
        for (int c = 0; c < 8; c++) begin
            k = -1;
            for (int i = rxq[c].size() - 1; i >= 0; i--) begin
                if (rxq[c][i] === sent[0][c*10+:10]) k = i;
            end
            if (k < 0) chk_frame(~sent[0][c*10+:10], sent[0][c*10+:10]);
            for (int j = 0; j < n && k >= 0; j++) begin
                chk_frame(rxq[c][k+j], sent[j][c*10+:10]);
            end
            if (k >= 0) chk_frame(rxq[c][k+n], sent[n-1][c*10+:10]);
        end
    endtask

    // whole sequence needs about 1.7k cycles; allow a wide margin
    initial begin
        #(20 * 40000);
        n_mismatch++;
        wrap_up();
    end

    initial begin
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        rdchk(ostl_pkg::OFF_CTRL, 32'h0000_00F0);
        rdchk(ostl_pkg::OFF_SLEEP, 32'h0000_00FF);
        rdchk(ostl_pkg::OFF_SYNC, 32'h0000_0000);
        rdchk(4'h2, 32'h0000_0000);
        bus(1'b1, ostl_pkg::OFF_CTRL, 32'h0000_0003, 4'hE);
        rdchk(ostl_pkg::OFF_CTRL, 32'h0000_00F0);
        chk_reg({24'h0, channel_serial_oe}, 32'h0000_0000);
        wr(ostl_pkg::OFF_SYNC, 32'h0000_00FF);
        wr(ostl_pkg::OFF_CTRL, 32'h0000_00F3);
        repeat (12 * 10) @(posedge clk_sys);
        rdchk(ostl_pkg::OFF_STATUS, 32'h0001_FF00);
        for (int c = 0; c < 8; c++) begin
            chk_frame(rxq[c][$], 10'h01F);
        end
        wr(ostl_pkg::OFF_SYNC, 32'h0000_0000);
        repeat (36) @(posedge clk_sys);
        for (int c = 0; c < 8; c++) rxq[c].delete();
        @(posedge clk_sys);
        for (int i = 0; i < 12; i++) begin
            rw = {$random(seed), $random(seed), $random(seed)};
            for (int c = 0; c < 8; c++) begin
                rw[c*10] = 1'b1;
                rw[c*10+9] = 1'b0;
            end
            push(rw[79:0]);
        end
        word_in_valid <= 1'b0;
        chk_reg({31'h0, saw_full}, 32'h0000_0001);
        repeat (12 * 16) @(posedge clk_sys);
        chk_stream();
        for (int a = 1; a >= 0; a--) begin
            for (int s = 0; s < 16; s++) begin
                wr(ostl_pkg::OFF_CTRL, {24'h0, s[3:0], 1'b0, a[0], 2'b11});
                repeat (30) @(posedge clk_sys);
                rd = (a == 0 || s > 8) ? 32'h0 :
                     (s == 8) ? 32'hFF : (32'h1 << s);
                rdchk(ostl_pkg::OFF_STATUS, rd | 32'h0001_0000);
            end
        end
        wr(ostl_pkg::OFF_CTRL, 32'h0000_0087);
        for (int c = 0; c < 8; c++) sz[c] = rxq[c].size();
        repeat (12 * 8) @(posedge clk_sys);
        rdchk(ostl_pkg::OFF_STATUS, 32'h0001_00FF);
        // up to two frames queued after the write still carry the old word
        for (int c = 0; c < 8; c++) begin
            for (int i = sz[c] + 3; i < rxq[c].size(); i++) begin
                chk_frame(rxq[c][i], prbs_next(rxq[c][i - 1]));
            end
        end
        chk_reg(n_err, 32'h0000_0000);
        wr(ostl_pkg::OFF_CTRL, 32'h0000_0002);
        repeat (4) @(posedge clk_sys);
        chk_reg({24'h0, channel_serial_oe}, 32'h0000_0000);
        wr(ostl_pkg::OFF_CTRL, 32'h0000_0003);
        repeat (4) @(posedge clk_sys);
        chk_reg({24'h0, channel_serial_oe}, 32'h0000_00FF);
        rdchk(ostl_pkg::OFF_STATUS, 32'h0001_0000);
        wr(ostl_pkg::OFF_SLEEP, 32'h0000_00FE);
        repeat (4) @(posedge clk_sys);
        chk_reg({24'h0, channel_serial_oe}, 32'h0000_00FE);
        wr(ostl_pkg::OFF_CTRL, 32'h0000_0001);
        repeat (4) @(posedge clk_sys);
        chk_reg({24'h0, channel_serial_oe}, 32'h0000_0000);
        rdchk(ostl_pkg::OFF_STATUS, 32'h0000_0000);
        wr(ostl_pkg::OFF_CTRL, 32'h0000_0003);
        rd = 32'h0;
        for (int i = 0; i < 40 && rd[16] !== 1'b1; i++) begin
            bus(1'b0, ostl_pkg::OFF_STATUS, 32'h0000_0000, 4'hF);
        end
        chk_reg(rd, 32'h0001_0000);
        wrap_up();
    end
endmodule // tb
